// ### src/dsl_pkg.sv
// Package for the serial converter load link: widths, variants and host timing.
// Assumes both ends and the interface are compiled after it.
package dsl_pkg;
  // Word shifted per frame and code widths of the two variants
  localparam int WORD_BITS = 16;
  localparam int WIDE_BITS = 16;
  localparam int NARROW_BITS = 14;
  localparam int BYTE_BITS = 8;
  // Variant select values
  localparam logic [0:0] VARIANT_WIDE = 1'h0;
  localparam logic [0:0] VARIANT_NARROW = 1'h1;
  // System clock period and link clock half period produced by the host
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_HALF_NS = 60;
  localparam int LINK_HALF_CYCLES = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] LINK_HALF_LAST = 4'(LINK_HALF_CYCLES - 1);
  localparam logic [4:0] BIT_COUNT_LAST = 5'(WORD_BITS - 1);
  // Host sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SETUP = 5'h02,
    ST_HIGH = 5'h04,
    ST_LOW = 5'h08,
    ST_STROBE = 5'h10
  } dsl_state_t;
endpackage

// ### src/dsl_link_if.sv
// Interface carrying the three-wire serial load link between host and converter.
// Assumes one driver per instance: the host drives all three wires of if0, the bench those of if1.
`timescale 1ns/1ns
interface dsl_link_if;
  logic select_n;
  logic serial_in;
  logic link_clk;
  modport host (output select_n, output serial_in, output link_clk);
  modport device (input select_n, input serial_in, input link_clk);
endinterface

// ### src/dsl_device.sv
// Converter end: samples the three-wire link and holds the converter code.
// Assumes the link comes from another clock domain and is synchronised here.
`timescale 1ns/1ns
// Function
// - Link clock rise with select low shifts
// - Earliest retained bit is code MSB
// - Only last sixteen shifted bits used
// - Select high: shifter and holding untouched
// - Select rise copies shifter to holding
// - Holding changes only at select rise
// - Host keeps clock still during strobe
// - Host presents data for rising sample
// - Wide variant maps B15..B0 to D15..D0
// - Narrow variant takes last fourteen bits
// - Host may send two bytes, MSB first
module dsl_device (
  input wire logic CLK,
  input wire logic RST_B,
  dsl_link_if.device LINK,
  input wire logic VARIANT,
  output logic [dsl_pkg::WIDE_BITS-1:0] CODE,
  output logic CODE_LOAD
);
  logic [2:0] sel_sync;
  logic [2:0] clk_sync;
  logic [1:0] dat_sync;
  logic [dsl_pkg::WORD_BITS-1:0] shifter;
  logic [dsl_pkg::WORD_BITS-1:0] next_shifter;
  logic [dsl_pkg::WIDE_BITS-1:0] next_code;
  logic next_code_load;
  logic link_rise;
  logic sel_rise;
  logic sel_low;

  // Two-stage synchronisers plus one history stage for edge detection
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sel_sync <= 3'h7;
      clk_sync <= 3'h0;
      dat_sync <= 2'h0;
    end else begin
      sel_sync <= {sel_sync[1:0], LINK.select_n};
      clk_sync <= {clk_sync[1:0], LINK.link_clk};
      dat_sync <= {dat_sync[0], LINK.serial_in};
    end
  end

  // Edges seen only on synchronised stages
  assign sel_low = !sel_sync[1];
  assign link_rise = clk_sync[1] && !clk_sync[2];
  assign sel_rise = sel_sync[1] && !sel_sync[2];

  // Shift and transfer decisions
  always_comb begin
    next_shifter = shifter;
    next_code = CODE;
    next_code_load = 1'b0;
    if (sel_low && link_rise) begin
      next_shifter = {shifter[dsl_pkg::WORD_BITS-2:0], dat_sync[1]};
    end
    if (sel_rise) begin
      next_code_load = 1'b1;
      if (VARIANT == dsl_pkg::VARIANT_NARROW) begin
        next_code = {{(dsl_pkg::WIDE_BITS-dsl_pkg::NARROW_BITS){1'b0}},
          shifter[dsl_pkg::NARROW_BITS-1:0]};
      end else begin
        next_code = shifter;
      end
    end
    // Otherwise select is high or idle and both registers keep their value
  end

  // Registers cleared on reset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      shifter <= '0;
      CODE <= '0;
      CODE_LOAD <= 1'b0;
    end else begin
      shifter <= next_shifter;
      CODE <= next_code;
      CODE_LOAD <= next_code_load;
    end
  end
endmodule

// ### src/dsl_host.sv
// Host end: sends one 16-bit word MSB first as two bytes, then strobes select.
// Assumes requests come from logic on the same clock.
`timescale 1ns/1ns
module dsl_host (
  input wire logic CLK,
  input wire logic RST_B,
  dsl_link_if.host LINK,
  input wire logic SEND_VALID,
  input wire logic [dsl_pkg::WORD_BITS-1:0] SEND_WORD,
  output logic SEND_READY,
  output logic SEND_DONE
);
  dsl_pkg::dsl_state_t state;
  dsl_pkg::dsl_state_t next_state;
  logic [dsl_pkg::WORD_BITS-1:0] word;
  logic [dsl_pkg::WORD_BITS-1:0] next_word;
  logic [3:0] tick;
  logic [3:0] next_tick;
  logic [4:0] bits;
  logic [4:0] next_bits;
  logic next_sel_n;
  logic next_sdo;
  logic next_sck;
  logic next_done;
  logic tick_end;

  assign tick_end = (tick == dsl_pkg::LINK_HALF_LAST);
  assign SEND_READY = (state == dsl_pkg::ST_IDLE);

  // Sequencer: divider-paced half periods of the link clock
  always_comb begin
    next_state = state;
    next_word = word;
    next_tick = tick_end ? 4'h0 : tick + 4'h1;
    next_bits = bits;
    next_sel_n = LINK.select_n;
    next_sdo = LINK.serial_in;
    next_sck = LINK.link_clk;
    next_done = 1'b0;
    case (state)
      dsl_pkg::ST_IDLE: begin
        next_tick = 4'h0;
        if (SEND_VALID) begin
          next_word = SEND_WORD; // Upper byte leads, then lower byte
          next_bits = 5'h0;
          next_sel_n = 1'b0;
          next_sdo = SEND_WORD[dsl_pkg::WORD_BITS-1]; // MSB first
          next_state = dsl_pkg::ST_SETUP;
        end
      end
      dsl_pkg::ST_SETUP: begin
        if (tick_end) begin
          next_sck = 1'b1; // Data stable before rising edge
          next_state = dsl_pkg::ST_HIGH;
        end
      end
      dsl_pkg::ST_HIGH: begin
        if (tick_end) begin
          next_sck = 1'b0;
          next_word = {word[dsl_pkg::WORD_BITS-2:0], 1'b0};
          next_sdo = word[dsl_pkg::WORD_BITS-2];
          next_state = (bits == dsl_pkg::BIT_COUNT_LAST) ? dsl_pkg::ST_LOW : dsl_pkg::ST_SETUP;
          next_bits = bits + 5'h1;
        end
      end
      dsl_pkg::ST_LOW: begin
        if (tick_end) begin
          next_sel_n = 1'b1; // Clock held low through the strobe
          next_state = dsl_pkg::ST_STROBE;
        end
      end
      dsl_pkg::ST_STROBE: begin
        if (tick_end) begin
          next_done = 1'b1;
          next_state = dsl_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = dsl_pkg::ST_IDLE;
        next_sel_n = 1'b1;
        next_sck = 1'b0;
      end
    endcase
  end

  // Registers of the sequencer and link pins
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= dsl_pkg::ST_IDLE;
      word <= '0;
      tick <= 4'h0;
      bits <= 5'h0;
      LINK.select_n <= 1'b1;
      LINK.serial_in <= 1'b0;
      LINK.link_clk <= 1'b0;
      SEND_DONE <= 1'b0;
    end else begin
      state <= next_state;
      word <= next_word;
      tick <= next_tick;
      bits <= next_bits;
      LINK.select_n <= next_sel_n;
      LINK.serial_in <= next_sdo;
      LINK.link_clk <= next_sck;
      SEND_DONE <= next_done;
    end
  end
endmodule

// ### test/dsl_link_asserts.sv
// Checker for the serial load link and the converter holding register.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ns
module dsl_link_asserts (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic select_n,
  input wire logic serial_in,
  input wire logic link_clk,
  input wire logic VARIANT,
  input wire logic [dsl_pkg::WIDE_BITS-1:0] CODE,
  input wire logic CODE_LOAD
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // Wire timing and holding register relations
  property p_load_after_rise; $rose(select_n) |-> ##[2:4] CODE_LOAD; endproperty
  a_load_after_rise: assert property (p_load_after_rise) else $error("no load after select rise");
  property p_code_only_on_load; !$stable(CODE) |-> CODE_LOAD; endproperty
  a_code_only_on_load: assert property (p_code_only_on_load) else $error("code moved without load");
  property p_load_pulse; CODE_LOAD |=> !CODE_LOAD; endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load longer than one cycle");
  property p_strobe_clk_still; $rose(select_n) |-> !link_clk && $stable(link_clk); endproperty
  a_strobe_clk_still: assert property (p_strobe_clk_still) else $error("link clock moved at strobe");
  property p_idle_clk_low; select_n |-> !link_clk; endproperty
  a_idle_clk_low: assert property (p_idle_clk_low) else $error("link clock high outside frame");
  property p_data_held_high; link_clk |-> $stable(serial_in); endproperty
  a_data_held_high: assert property (p_data_held_high) else $error("data moved while clock high");
  property p_half_period; $rose(link_clk) |-> link_clk [*6]; endproperty
  a_half_period: assert property (p_half_period) else $error("link clock high too short");
  property p_narrow_top; CODE_LOAD && VARIANT |-> CODE[15:14] == 2'h0; endproperty
  a_narrow_top: assert property (p_narrow_top) else $error("narrow code top bits set");
endmodule

// ### test/dac_serial_load_interface_tb_top.sv
// Bench joining host and converter ends, plus a bench-driven far link.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/1ns
module dac_serial_load_interface_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic variant = 1'b0;
  logic send_valid = 1'b0;
  logic [15:0] send_word = 16'h0000;
  logic send_ready, send_done, code_load;
  logic [15:0] code, code2;
  int failures = 0;
  int tests_run = 0;
  dsl_link_if if0();
  dsl_link_if if1();
  // System clock
  always #5 clk = ~clk;
  dsl_host dsl_host_i (.CLK(clk), .RST_B(rst_b), .LINK(if0), .SEND_VALID(send_valid), .SEND_WORD(send_word),
    .SEND_READY(send_ready), .SEND_DONE(send_done));
  dsl_device dsl_device_i (.CLK(clk), .RST_B(rst_b), .LINK(if0), .VARIANT(variant), .CODE(code),
    .CODE_LOAD(code_load));
  dsl_device dsl_device_i2 (.CLK(clk), .RST_B(rst_b), .LINK(if1), .VARIANT(1'b0), .CODE(code2), .CODE_LOAD());
  dsl_link_asserts dsl_link_asserts_i (.CLK(clk), .RST_B(rst_b), .select_n(if0.select_n),
    .serial_in(if0.serial_in), .link_clk(if0.link_clk), .VARIANT(variant), .CODE(code), .CODE_LOAD(code_load));
  // Compare and count
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One word through the host, bounded wait for its completion
  task automatic send(input logic [15:0] w);
    int n;
    @(negedge clk);
    send_valid = 1'b1;
    send_word = w;
    @(negedge clk);
    send_valid = 1'b0;
    chk("ready busy", {15'h0000, send_ready}, 16'h0000);
    for (n = 0; n < 400 && send_done !== 1'b1; n++) @(negedge clk);
    if (n == 400) begin
      failures++;
      tally_and_finish();
    end
    repeat (4) @(negedge clk);
    chk("ready idle", {15'h0000, send_ready}, 16'h0001);
  endtask
  task automatic t_wide();
    variant = 1'b0;
    send(16'ha5c3);
    chk("wide", code, 16'ha5c3);
    send(16'h8001);
    chk("wide", code, 16'h8001);
    $display("wide done");
  endtask
  task automatic t_narrow();
    variant = 1'b1;
    send(16'hffff);
    chk("narrow", code, 16'h3fff);
    send(16'hc001);
    chk("narrow", code, 16'h0001);
    $display("narrow done");
  endtask
  // One bit on the far link, driven on falling edges; low phases of 6 and 7 cycles average a 125 ns period
  task automatic lbit(input logic b, input int lo);
    if1.serial_in = b;
    repeat (lo) @(negedge clk);
    if1.link_clk = 1'b1;
    repeat (6) @(negedge clk);
    if1.link_clk = 1'b0;
  endtask
  task automatic t_raw();
    int i;
    logic [19:0] bits;
    bits = 20'hf1234;
    repeat (10) @(negedge clk);
    if1.select_n = 1'b0;
    for (i = 19; i >= 0; i--) lbit(bits[i], 6 + i[0]);
    chk("before strobe", code2, 16'h0000);
    repeat (10) @(negedge clk);
    if1.select_n = 1'b1;
    repeat (10) @(negedge clk);
    chk("last sixteen", code2, 16'h1234);
    for (i = 0; i < 4; i++) lbit(1'b1, 6 + i[0]);
    repeat (10) @(negedge clk);
    if1.select_n = 1'b0;
    for (i = 7; i >= 0; i--) lbit(i[0], 6 + i[0]);
    chk("held", code2, 16'h1234);
    repeat (10) @(negedge clk);
    if1.select_n = 1'b1;
    repeat (10) @(negedge clk);
    chk("idle clocks ignored", code2, 16'h34aa);
    $display("far link done");
  endtask
  initial begin
    if1.select_n = 1'b1;
    if1.serial_in = 1'b0;
    if1.link_clk = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    chk("reset", code, 16'h0000);
    chk("reset ready", {15'h0000, send_ready}, 16'h0001);
    $display("reset done");
    t_wide();
    t_narrow();
    t_raw();
    tally_and_finish();
  end
endmodule
